/* File: hw/lin_phy_cfg.svh */
// Address map, field positions, reset values and timing of the LIN control
`ifndef LIN_PHY_CFG_SVH
`define LIN_PHY_CFG_SVH
`define BASE_BLOCKING 4'h2
`define BASE_NONBLOCK 4'h3
`define OFS_CTL 8'h50
`define OFS_FLAGS 8'h52
`define OFS_LINE 8'h53
`define OFS_TXSRC 8'h54
`define OFS_RXRT 8'h55
`define OFS_SPARE_A 8'h56
`define OFS_SPARE_B 8'h57
`define CTL_RESET 8'h00
`define BYTE_RESET 8'h00
`define B_OVERTEMP_IRQ_ALLOW_GATE 15
`define B_FORCE_GATE 12
`define B_UVKA_GATE 11
`define B_ACT_GATE 10
`define B_RATE_GATE_HI 9
`define B_RATE_GATE_LO 8
`define B_OVERTEMP_IRQ_ALLOW 7
`define B_FORCE 4
`define B_UVKA 3
`define B_ACT 2
`define B_RATE_HI 1
`define B_RATE_LO 0
`define B_OT 7
`define B_HF 5
`define B_UV 3
`define B_RDY 7
`define B_RXL 1
`define B_TXL 0
`define B_SEL_PORT 1
`define B_SEL_UART 0
`define SEL_BOTH 2'h3
`define RATE_GATE_ALL 2'h3
`define RATE_SLOW 2'h1
`define RATE_FAST 2'h2
`define READY_TIME_US 50
`define CLK_MHZ 200
`define READY_CNT_W 14
`endif

/* File: hw/lin_phy_ctrl.sv */
// LIN physical layer control, status and routing register bank
`include "lin_phy_cfg.svh"
module lin_phy_ctrl #(
  parameter int READY_CYCLES = `READY_TIME_US * `CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [11:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic overtemp_i,
  input wire logic rf_disturb_i,
  input wire logic undervolt_i,
  input wire logic uart_tx_i,
  input wire logic port_tx_i,
  input wire logic line_rx_dominant_i,
  output logic tx_dominant_o,
  output logic rx_uart_o,
  output logic rx_port_o,
  output logic overtemp_irq_o,
  output logic active_o,
  output lin_phy_pkg::edge_rate_e edge_rate_o
);
  import lin_phy_pkg::*;

  function automatic logic gated(input logic gate, input logic nv,
                                 input logic ov);
    gated = gate ? nv : ov;
  endfunction : gated

  ready_if rdy ();

  logic overtemp_irq_allow_q, force_q, uvka_q, act_q;
  logic [1:0] rate_q;
  logic ot_flag_q, hf_flag_q, uv_flag_q;
  logic ot_cond_q, hf_cond_q, uv_cond_q;
  logic [1:0] txsrc_q, rxrt_q;
  logic [15:0] rdata_q;
  logic tx_q;

  wire logic [3:0] page = addr_i[11:8];
  wire logic [7:0] ofs = addr_i[7:0];
  wire logic in_bank = (page == `BASE_BLOCKING) ||
                       (page == `BASE_NONBLOCK);
  wire logic sel_ctl = in_bank && (ofs == `OFS_CTL);
  wire logic sel_flags = in_bank && (ofs == `OFS_FLAGS);
  wire logic sel_line = in_bank && (ofs == `OFS_LINE);
  wire logic sel_txsrc = in_bank && (ofs == `OFS_TXSRC);
  wire logic sel_rxrt = in_bank && (ofs == `OFS_RXRT);
  // whole word taken on the control offset
  wire logic wr_ctl = wr_i && sel_ctl;
  wire logic wr_flags = wr_i && sel_flags;

  // Control word updates, each field behind its own gate bit, the edge rate behind two
  // interrupt allow gate
  wire logic overtemp_irq_allow_d = gated(wr_ctl && wdata_i[`B_OVERTEMP_IRQ_ALLOW_GATE],
                            wdata_i[`B_OVERTEMP_IRQ_ALLOW], overtemp_irq_allow_q);
  wire logic force_d = gated(wr_ctl && wdata_i[`B_FORCE_GATE],
                             wdata_i[`B_FORCE], force_q);
  wire logic uvka_d = gated(wr_ctl && wdata_i[`B_UVKA_GATE],
                            wdata_i[`B_UVKA], uvka_q);
  wire logic act_d = gated(wr_ctl && wdata_i[`B_ACT_GATE],
                           wdata_i[`B_ACT], act_q);
  // edge rate needs both gate bits
  wire logic rate_we = wr_ctl &&
    (wdata_i[`B_RATE_GATE_HI:`B_RATE_GATE_LO] == `RATE_GATE_ALL);
  wire logic [1:0] rate_d =
    rate_we ? wdata_i[`B_RATE_HI:`B_RATE_LO] : rate_q;

  // Control word storage
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overtemp_irq_allow_q <= 1'b0;
      force_q <= 1'b0;
      uvka_q <= 1'b0;
      act_q <= 1'b0;
      rate_q <= 2'h0;
    end else begin
      overtemp_irq_allow_q <= overtemp_irq_allow_d;
      force_q <= force_d;
      uvka_q <= uvka_d;
      act_q <= act_d;
      rate_q <= rate_d;
    end
  end

  // flags set on condition onset, set beats clear
  wire logic ot_set = overtemp_i && !ot_cond_q;
  wire logic hf_set = rf_disturb_i && !hf_cond_q;
  wire logic uv_set = undervolt_i && !uv_cond_q;
  wire logic ot_clr = wr_flags && wdata_i[`B_OT];
  wire logic hf_clr = wr_flags && wdata_i[`B_HF];
  wire logic uv_clr = wr_flags && wdata_i[`B_UV];

  // Condition history and sticky flags
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ot_cond_q <= 1'b0;
      hf_cond_q <= 1'b0;
      uv_cond_q <= 1'b0;
      ot_flag_q <= 1'b0;
      hf_flag_q <= 1'b0;
      uv_flag_q <= 1'b0;
    end else begin
      ot_cond_q <= overtemp_i;
      hf_cond_q <= rf_disturb_i;
      uv_cond_q <= undervolt_i;
      ot_flag_q <= ot_set || (ot_flag_q && !ot_clr);
      hf_flag_q <= hf_set || (hf_flag_q && !hf_clr);
      uv_flag_q <= uv_set || (uv_flag_q && !uv_clr);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      txsrc_q <= 2'h0;
      rxrt_q <= 2'h0;
    end else begin
      if (wr_i && sel_txsrc) begin
        txsrc_q <= wdata_i[`B_SEL_PORT:`B_SEL_UART];
      end
      if (wr_i && sel_rxrt) begin
        rxrt_q <= wdata_i[`B_SEL_PORT:`B_SEL_UART];
      end
    end
  end

  assign rdy.enable = act_q;
  ready_timer #(
    .READY_CYCLES(READY_CYCLES)
  ) u_ready (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .rdy(rdy)
  );

  // UART has priority over port, then OR force
  wire logic src_bit = txsrc_q[`B_SEL_UART] ? uart_tx_i :
                       (txsrc_q[`B_SEL_PORT] && port_tx_i);
  wire logic tx_req = src_bit || force_q;
  wire logic uv_block = undervolt_i && !uvka_q;
  // recessive until ready, also off when hot
  wire logic tx_ok = act_q && rdy.ready && !overtemp_i && !uv_block;
  wire logic tx_d = tx_req && tx_ok;

  // Registered transmitter drive
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
    end
  end

  wire logic [7:0] line_byte = {rdy.ready, 5'h00, line_rx_dominant_i,
                                tx_q};
  // unused and gate bits read zero
  wire logic [15:0] ctl_word = {8'h00, overtemp_irq_allow_q, 2'h0, force_q, uvka_q,
                                act_q, rate_q};
  wire logic [7:0] flag_byte = {ot_flag_q, 1'b0, hf_flag_q, 1'b0,
                                uv_flag_q, 3'h0};
  wire logic [15:0] rdata_d =
    sel_ctl ? ctl_word :
    sel_flags ? {8'h00, flag_byte} :
    sel_line ? {8'h00, line_byte} :
    sel_txsrc ? {14'h0000, txsrc_q} :
    sel_rxrt ? {14'h0000, rxrt_q} : 16'h0000;

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rd_i ? rdata_d : 16'h0000;
    end
  end

  assign rdata_o = rdata_q;
  assign tx_dominant_o = tx_q;
  assign rx_uart_o = rxrt_q[`B_SEL_UART] && line_rx_dominant_i;
  assign rx_port_o = rxrt_q[`B_SEL_PORT] && line_rx_dominant_i;
  // interrupt gated by allow bit; edge-set flag
  assign overtemp_irq_o = ot_flag_q && overtemp_irq_allow_q;
  assign active_o = act_q;
  assign edge_rate_o = (rate_q == `RATE_SLOW) ? EDGE_SLOW :
                       (rate_q == `RATE_FAST) ? EDGE_FAST : EDGE_NORMAL;

  a_overtemp_irq_allow_gate_hold: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_ctl && !wdata_i[`B_OVERTEMP_IRQ_ALLOW_GATE]) |=> $stable(overtemp_irq_allow_q))
    else $error("interrupt allow changed without its gate");
  a_force_gate_load: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_ctl && wdata_i[`B_FORCE_GATE]) |=>
      (force_q == $past(wdata_i[`B_FORCE])))
    else $error("force bit not loaded with gate set");
  a_rate_partial_gate: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_ctl && !rate_we) |=> $stable(rate_q))
    else $error("edge rate changed with partial gate");
  a_flag_clear_w1c: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (ot_clr && !ot_set) |=> !ot_flag_q)
    else $error("over-temperature flag not cleared");
  a_flag_sticky_hold: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (uv_flag_q && !uv_clr) |=> uv_flag_q)
    else $error("undervoltage flag dropped without a clear");
  a_irq_new_onset: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(ot_flag_q) |-> $past(overtemp_i) && !$past(ot_cond_q))
    else $error("over-temperature flag set without new onset");
  a_not_ready_recessive: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !rdy.ready |=> !tx_q)
    else $error("transmitter dominant before ready");
  a_uart_wins_port: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (txsrc_q == `SEL_BOTH && tx_ok && !force_q) |=>
      (tx_q == $past(uart_tx_i)))
    else $error("port source not ignored when UART selected");
  a_uv_keeps_recessive: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (undervolt_i && !uvka_q) |=> !tx_q)
    else $error("dominant driven during undervoltage");
  a_spare_read_zero: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (rd_i && in_bank && (ofs == `OFS_SPARE_A || ofs == `OFS_SPARE_B))
      |=> (rdata_o == 16'h0000))
    else $error("reserved offset read not zero");

  // Field gates, transmit paths, routing, read-back, page decode and flag set/clear
  a_overtemp_irq_allow_gate_load: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_ctl && wdata_i[`B_OVERTEMP_IRQ_ALLOW_GATE]) |=>
      (overtemp_irq_allow_q == $past(wdata_i[`B_OVERTEMP_IRQ_ALLOW])))
    else $error("interrupt allow not loaded with gate set");
  a_force_gate_hold: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_ctl && !wdata_i[`B_FORCE_GATE]) |=> $stable(force_q))
    else $error("force bit changed without its gate");
  a_uvka_gate_hold: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_ctl && !wdata_i[`B_UVKA_GATE]) |=> $stable(uvka_q))
    else $error("keep-alive changed without its gate");
  a_uvka_gate_load: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_ctl && wdata_i[`B_UVKA_GATE]) |=>
      (uvka_q == $past(wdata_i[`B_UVKA])))
    else $error("keep-alive not loaded with gate set");
  a_act_gate_hold: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_ctl && !wdata_i[`B_ACT_GATE]) |=> $stable(act_q))
    else $error("module enable changed without its gate");
  a_act_gate_load: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_ctl && wdata_i[`B_ACT_GATE]) |=>
      (act_q == $past(wdata_i[`B_ACT])))
    else $error("module enable not loaded with gate set");
  a_rate_full_gate: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    rate_we |=> (rate_q == $past(wdata_i[`B_RATE_HI:`B_RATE_LO])))
    else $error("edge rate not loaded with full gate");
  a_force_drives_dom: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (force_q && tx_ok) |=> tx_q)
    else $error("force bit did not drive dominant");
  a_disabled_recessive: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !act_q |=> !tx_q)
    else $error("transmitter dominant while disabled");
  a_ready_needs_enable: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !act_q |=> !rdy.ready)
    else $error("ready held while disabled");
  a_no_source_quiet: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (txsrc_q == '0 && !force_q) |=> !tx_q)
    else $error("dominant driven with no source selected");
  a_port_source_used: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (txsrc_q[`B_SEL_PORT] && !txsrc_q[`B_SEL_UART] && tx_ok && !force_q)
      |=> (tx_q == $past(port_tx_i)))
    else $error("port source not passed to transmitter");
  a_source_reg_write: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_i && sel_txsrc) |=>
      (txsrc_q == $past(wdata_i[`B_SEL_PORT:`B_SEL_UART])))
    else $error("source select not written");
  a_route_reg_write: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_i && sel_rxrt) |=>
      (rxrt_q == $past(wdata_i[`B_SEL_PORT:`B_SEL_UART])))
    else $error("receive route not written");
  a_read_idle_zero: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !rd_i |=> (rdata_o == 16'h0000))
    else $error("read data not zero outside a read");
  a_gate_bits_zero: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (rd_i && sel_ctl) |=>
      (rdata_o[`B_OVERTEMP_IRQ_ALLOW_GATE:`B_RATE_GATE_LO] == 8'h00))
    else $error("control gate bits did not read zero");
  a_line_state_read: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (rd_i && sel_line) |=>
      (rdata_o[`B_RDY] == $past(rdy.ready)) &&
      (rdata_o[`B_RXL] == $past(line_rx_dominant_i)) &&
      (rdata_o[`B_TXL] == $past(tx_q)))
    else $error("line state read wrong");
  a_off_page_ignored: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_i && !in_bank) |=>
      $stable({overtemp_irq_allow_q, force_q, uvka_q, act_q, rate_q, txsrc_q, rxrt_q}))
    else $error("write outside the bank changed a register");
  a_flag_set_onset: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ot_set |=> ot_flag_q)
    else $error("over-temperature onset not latched");
  a_uv_flag_clear: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (uv_clr && !uv_set) |=> !uv_flag_q)
    else $error("undervoltage flag not cleared");
endmodule : lin_phy_ctrl

/* File: hw/lin_phy_pkg.sv */
// Types shared by the LIN control modules
package lin_phy_pkg;
  typedef enum logic [2:0] {
    RDY_IDLE = 3'h1,
    RDY_WAIT = 3'h2,
    RDY_DONE = 3'h4
  } ready_state_e;
  typedef enum logic [2:0] {
    EDGE_NORMAL = 3'h1,
    EDGE_SLOW = 3'h2,
    EDGE_FAST = 3'h4
  } edge_rate_e;
endpackage : lin_phy_pkg

/* File: hw/ready_if.sv */
// Enable and ready handshake between control bank and ready timer
interface ready_if;
  logic enable;
  logic ready;
  modport ctrl (output enable, input ready);
  modport timer (input enable, output ready);
endinterface : ready_if

/* File: hw/ready_timer.sv */
// Transmitter start-up timer that raises ready after the settle time
`include "lin_phy_cfg.svh"
module ready_timer #(
  parameter int READY_CYCLES = `READY_TIME_US * `CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  ready_if.timer rdy
);
  import lin_phy_pkg::*;
  localparam logic [`READY_CNT_W-1:0] LAST =
    `READY_CNT_W'(READY_CYCLES - 1);
  ready_state_e state_q, state_d;
  logic [`READY_CNT_W-1:0] cnt_q, cnt_d;
  wire logic at_last = (cnt_q == LAST);

  // Next state: any drop of enable restarts the wait
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      RDY_IDLE: begin
        cnt_d = '0;
        if (rdy.enable) begin
          state_d = RDY_WAIT;
        end
      end
      RDY_WAIT: begin
        cnt_d = cnt_q + `READY_CNT_W'(1);
        if (!rdy.enable) begin
          state_d = RDY_IDLE;
        end else if (at_last) begin
          state_d = RDY_DONE;
        end
      end
      RDY_DONE: begin
        if (!rdy.enable) begin
          state_d = RDY_IDLE;
        end
      end
      default: begin
        state_d = RDY_IDLE;
      end
    endcase
  end

  // State and counter
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= RDY_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign rdy.ready = (state_q == RDY_DONE);

  a_ready_after_wait: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(rdy.ready) |-> $past(at_last) && $past(rdy.enable))
    else $error("ready rose before the settle count ended");
endmodule : ready_timer

/* File: verif/lin_node_model.sv */
// Peer LIN node sharing the single-wire bus with the device
module lin_node_model (
  input wire logic dut_dominant_i,
  input wire logic peer_dominant_i,
  output logic line_dominant_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Any node driving dominant pulls the shared line dominant
  assign line_dominant_o = dut_dominant_i | peer_dominant_i;
endmodule : lin_node_model

/* File: verif/lin_phy_ctrl_tb.sv */
// Self-checking bench for the LIN control register bank
module lin_phy_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lin_phy_pkg::*;
  typedef struct {
    logic [11:0] a;
    logic [15:0] w;
    logic [15:0] e;
  } row_s;
  localparam int WATCH_CYCLES = 4000;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic overtemp_i = 1'b0;
  logic rf_disturb_i = 1'b0;
  logic undervolt_i = 1'b0;
  logic uart_tx_i = 1'b0;
  logic port_tx_i = 1'b0;
  logic peer_dom = 1'b0;
  logic line_rx;
  logic [15:0] rdata_o;
  logic tx_dominant_o;
  logic rx_uart_o;
  logic rx_port_o;
  logic overtemp_irq_o;
  logic active_o;
  edge_rate_e edge_rate_o;
  int n_errors = 0;
  int n_tests = 0;
  edge_rate_e rate_exp [4] = '{EDGE_NORMAL, EDGE_SLOW, EDGE_FAST, EDGE_NORMAL};
  // Write, then read back from the same address
  row_s rows [8] = '{
    '{12'h250, 16'h0484, 16'h0004},
    '{12'h350, 16'h8080, 16'h0084},
    '{12'h250, 16'h0103, 16'h0084},
    '{12'h250, 16'h0302, 16'h0086},
    '{12'h254, 16'h00FF, 16'h0003},
    '{12'h355, 16'h0003, 16'h0003},
    '{12'h256, 16'h00FF, 16'h0000},
    '{12'h150, 16'h0484, 16'h0000}
  };

  lin_phy_ctrl #(.READY_CYCLES(8)) i_lin_phy_ctrl (.clk_i(clk_i),
    .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .overtemp_i(overtemp_i),
    .rf_disturb_i(rf_disturb_i), .undervolt_i(undervolt_i),
    .uart_tx_i(uart_tx_i), .port_tx_i(port_tx_i),
    .line_rx_dominant_i(line_rx), .tx_dominant_o(tx_dominant_o),
    .rx_uart_o(rx_uart_o), .rx_port_o(rx_port_o),
    .overtemp_irq_o(overtemp_irq_o), .active_o(active_o),
    .edge_rate_o(edge_rate_o));
  lin_node_model i_lin_node_model (.dut_dominant_i(tx_dominant_o),
    .peer_dominant_i(peer_dom), .line_dominant_o(line_rx));

  // Clock at 200 MHz
  always #2.5 clk_i = ~clk_i;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask : chk
  task automatic ck1(input logic got, input logic exp, input string m);
    chk({15'h0000, got}, {15'h0000, exp}, m);
  endtask : ck1
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] e,
                    input string m);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e, m);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Watchdog against a hung run
  initial begin
    repeat (WATCH_CYCLES) @(posedge clk_i);
    n_errors++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    cyc(1);
    ck1(active_o, 1'b0, "reset active");
    chk(16'(edge_rate_o), 16'(EDGE_NORMAL), "reset rate");
    rd(12'h250, 16'h0000, "reset ctl");
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e, "table row");
    end
    ck1(active_o, 1'b1, "active");
    $display("test table done");
    for (int r = 0; r < 4; r++) begin
      wr(12'h250, 16'h0300 | 16'(r));
      cyc(1);
      chk({13'h0000, edge_rate_o}, {13'h0000, rate_exp[r]}, "rate");
    end
    $display("test rate done");
    wr(12'h250, 16'h0400);
    wr(12'h250, 16'h1414);
    cyc(2);
    ck1(tx_dominant_o, 1'b0, "tx before ready");
    cyc(12);
    ck1(tx_dominant_o, 1'b1, "force");
    wr(12'h253, 16'h00FF);
    rd(12'h253, 16'h0083, "line state");
    undervolt_i <= 1'b1;
    cyc(2);
    ck1(tx_dominant_o, 1'b0, "uv recessive");
    wr(12'h250, 16'h0808);
    cyc(2);
    ck1(tx_dominant_o, 1'b1, "keep alive");
    undervolt_i <= 1'b0;
    wr(12'h250, 16'h1000);
    port_tx_i <= 1'b1;
    cyc(2);
    ck1(tx_dominant_o, 1'b0, "uart wins");
    uart_tx_i <= 1'b1;
    cyc(2);
    ck1(tx_dominant_o, 1'b1, "uart src");
    wr(12'h254, 16'h0002);
    uart_tx_i <= 1'b0;
    cyc(2);
    ck1(tx_dominant_o, 1'b1, "port src");
    $display("test transmit done");
    port_tx_i <= 1'b0;
    cyc(2);
    ck1(rx_uart_o, 1'b0, "rx idle");
    peer_dom <= 1'b1;
    cyc(1);
    ck1(rx_uart_o, 1'b1, "rx uart");
    ck1(rx_port_o, 1'b1, "rx port");
    rd(12'h353, 16'h0082, "line peer");
    wr(12'h255, 16'h0001);
    cyc(1);
    ck1(rx_port_o, 1'b0, "rx unrouted");
    ck1(rx_uart_o, 1'b1, "rx routed");
    peer_dom <= 1'b0;
    port_tx_i <= 1'b1;
    $display("test receive done");
    wr(12'h252, 16'h00FF);
    overtemp_i <= 1'b1;
    rf_disturb_i <= 1'b1;
    cyc(2);
    ck1(tx_dominant_o, 1'b0, "overtemp off");
    rd(12'h252, 16'h00A0, "flags set");
    ck1(overtemp_irq_o, 1'b1, "irq");
    wr(12'h252, 16'h0080);
    rd(12'h252, 16'h0020, "ot held");
    ck1(overtemp_irq_o, 1'b0, "irq ack");
    overtemp_i <= 1'b0;
    cyc(1);
    overtemp_i <= 1'b1;
    cyc(2);
    rd(12'h252, 16'h00A0, "ot again");
    wr(12'h250, 16'h8000);
    cyc(1);
    ck1(overtemp_irq_o, 1'b0, "irq masked");
    wr(12'h252, 16'h0020);
    rd(12'h252, 16'h0080, "w1c");
    $display("test flags done");
    // Mid-run reset clears transmit drive, enable, source select, flags and control word
    overtemp_i <= 1'b0;
    rf_disturb_i <= 1'b0;
    resetn_i <= 1'b0;
    cyc(2);
    ck1(tx_dominant_o, 1'b0, "reset tx");
    ck1(active_o, 1'b0, "reset enable");
    resetn_i <= 1'b1;
    rd(12'h254, 16'h0000, "reset source");
    rd(12'h252, 16'h0000, "reset flags");
    rd(12'h250, 16'h0000, "reset word");
    $display("test reset again done");
    summarize();
  end
endmodule : lin_phy_ctrl_tb
